// file: verilog/acc_pkg.sv
/*
  Shared constants for the converter control block: register offsets, field
  positions, reset values and conversion timing.
  Assumes a plain register port with a small address and 8-bit data.
*/
`default_nettype none

package acc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PINSEL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_INTCTL = 4'h3;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_ON = 0;
    localparam int BIT_GO = 1;
    localparam int CHAN_LSB = 2;
    localparam int CHAN_W = 4;
    localparam int CLKSEL_LSB = 6;
    localparam int CLKSEL_W = 2;
    localparam int BIT_DONE_FLAG = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ANS_RESET = 8'hFF;
    localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // conversion clock divisors, indexed by the clock selector
    // ------------------------------------------------------------------
    localparam int DIV_W = 5;
    localparam logic [CLKSEL_W-1:0] CLKSEL_INTERNAL_OSCILLATOR = 2'h3;
    localparam logic [DIV_W-1:0] DIV_SEL0 = 5'h10;
    localparam logic [DIV_W-1:0] DIV_SEL1 = 5'h08;
    localparam logic [DIV_W-1:0] DIV_SEL2 = 5'h04;
    localparam logic [DIV_W-1:0] DIV_INTERNAL_OSCILLATOR = 5'h04;

    // ------------------------------------------------------------------
    // conversion timing in bit periods
    // ------------------------------------------------------------------
    localparam logic [3:0] TAD_PER_CONV = 4'hD;
    localparam logic [3:0] LAST_TAD = TAD_PER_CONV - 4'h1;
    localparam logic [3:0] TAD_SAMPLE = 4'h0;
    localparam logic [3:0] TAD_FIRST_DECIDE = 4'h1;
    localparam logic [3:0] TAD_LAST_DECIDE = 4'h8;
    localparam logic [7:0] TRIAL_MSB = 8'h80;

endpackage

`default_nettype wire

// file: verilog/acc_tad_divider.sv
/*
  Bit-period tick generator: divides the instruction clock, or the pulses of
  the internal oscillator enable, by the selected divisor.
  Assumes the selector is held stable by the caller while it runs.
*/
`timescale 1ns/1ps
`default_nettype none

module acc_tad_divider
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [CLKSEL_W-1:0] divSel,
    input wire logic intOscTick,
    // tick out
    output logic tick
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } acc_div_state_t;

    acc_div_state_t q;
    acc_div_state_t d;
    logic [DIV_W-1:0] divisor;
    logic srcPulse;

    // ------------------------------------------------------------------
    // divisor select
    // ------------------------------------------------------------------
    always_comb begin
        divisor = DIV_SEL0;
        srcPulse = 1'b1;
        case (divSel)
            2'h0: divisor = DIV_SEL0;
            2'h1: divisor = DIV_SEL1;
            2'h2: divisor = DIV_SEL2;
            default: begin
                divisor = DIV_INTERNAL_OSCILLATOR;
                srcPulse = intOscTick;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (restart) begin
            d.cnt = '0;
        end else if (run && srcPulse) begin
            if (q.cnt == divisor - 5'h01) begin
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule // acc_tad_divider

`default_nettype wire

// file: verilog/acc_conversion_control.sv
/*
  Control logic of an 8-bit successive approximation converter: clock
  selection, analog pin select, channel routing, start/done sequencing,
  completion flag and result register.
  Assumes an external comparator answering "input at or above trial code"
  and a core that pulses sleepEnter on Sleep entry.
*/
// Design decisions made here: the placing of the registers and the strobed register port.
// What this block does
// - two-bit selector picks divide by 16, 8, 4 or internal oscillator over 4
// - each conversion takes exactly 13 bit periods at any divisor
// - converter clock comes from the instruction clock through the divisor, or from the internal oscillator pulses at selector 3
// - a selector change during a conversion applies from the next start
// - Sleep entry returns the clock selector to its reset value
// - eight analog pin select bits reset to all ones
// - a pin marked analog gets no digital output drive
// - pin select works whether the converter is on or off
// - channel writes accepted anytime, routed only once no conversion runs
// - Sleep entry discards all channel selection
// - setting start/done begins a conversion; it reads one while running
// - completion clears start/done and sets the done flag
// - clearing start/done aborts at once, partial result may remain
// - Sleep entry clears start/done and stops any conversion
// - start is ignored while the converter-on bit is clear
// - result is an 8-bit unsigned code referenced to the supply
// - result is an 8-bit readable and writable register
`timescale 1ns/1ps
`default_nettype none

module acc_conversion_control
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // core events
    input wire logic sleepEnter,
    input wire logic intOscTick,
    // pin drive
    input wire logic [7:0] pinDriveReq,
    output logic [7:0] pinDriveEn,
    output logic [7:0] analogPinSelect,
    // analog side
    input wire logic compAbove,
    output logic [CHAN_W-1:0] inputChannelSelect,
    output logic [7:0] trialCode,
    output logic convBusy,
    // status
    output logic conversionDoneFlag
);

    typedef struct packed {
        logic ctrlOn;
        logic go;
        logic [CLKSEL_W-1:0] clkSel;
        logic [CLKSEL_W-1:0] activeSel;
        logic [CHAN_W-1:0] chanReq;
        logic [CHAN_W-1:0] chanRoute;
        logic [7:0] analog_pin_select;
        logic [7:0] result;
        logic flag;
        logic [7:0] trial;
        logic [2:0] bitIdx;
        logic [3:0] tadCount;
        logic restart;
        logic compS1;
        logic compS2;
        logic [7:0] readData;
        logic [7:0] pinOe;
    } acc_state_t;

    localparam acc_state_t STATE_RESET = '{
        analog_pin_select: ANS_RESET,
        clkSel: CLKSEL_RESET,
        activeSel: CLKSEL_RESET,
        chanReq: CHAN_RESET,
        chanRoute: CHAN_RESET,
        result: RESULT_RESET,
        default: '0
    };

    acc_state_t q;
    acc_state_t d;
    logic tick;
    logic wrCtrl;
    logic wrPinSel;
    logic wrResult;
    logic wrIntCtl;
    logic finish;
    logic startReq;
    logic abortReq;

    // ------------------------------------------------------------------
    // bit-period divider
    // ------------------------------------------------------------------
    // divider runs off the selector latched at start, not the live one
    acc_tad_divider u_divider (
        .clock(clock),
        .nrst(nrst),
        .run(q.go),
        .restart(q.restart),
        .divSel(q.activeSel),
        .intOscTick(intOscTick),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    always_comb begin
        wrCtrl = regWrite && (regAddr == OFS_CTRL);
        wrPinSel = regWrite && (regAddr == OFS_PINSEL);
        wrResult = regWrite && (regAddr == OFS_RESULT);
        wrIntCtl = regWrite && (regAddr == OFS_INTCTL);
        finish = q.go && tick && (q.tadCount == LAST_TAD);
        startReq = wrCtrl && regWriteData[BIT_GO] && regWriteData[BIT_ON] && !q.go;
        // turning the converter off mid-conversion aborts as well
        abortReq = wrCtrl && q.go && !(regWriteData[BIT_GO] && regWriteData[BIT_ON]);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.restart = 1'b0;
        d.readData = 8'h00;
        d.compS1 = compAbove;
        d.compS2 = q.compS1;

        // plain register writes
        if (wrCtrl) begin
            d.ctrlOn = regWriteData[BIT_ON];
            d.clkSel = regWriteData[CLKSEL_LSB +: CLKSEL_W];
            d.chanReq = regWriteData[CHAN_LSB +: CHAN_W];
        end
        if (wrPinSel) begin
            d.analog_pin_select = regWriteData;
        end
        if (wrResult) begin
            d.result = regWriteData;
        end
        if (wrIntCtl && !regWriteData[BIT_DONE_FLAG]) begin
            d.flag = 1'b0;
        end

        // successive approximation, one step per bit period
        if (q.go && tick) begin
            d.tadCount = q.tadCount + 4'h1;
            if (q.tadCount == TAD_SAMPLE) begin
                d.trial = TRIAL_MSB;
                d.bitIdx = 3'h7;
            end else if ((q.tadCount >= TAD_FIRST_DECIDE) &&
                         (q.tadCount <= TAD_LAST_DECIDE)) begin
                if (!q.compS2) begin
                    d.trial[q.bitIdx] = 1'b0;
                end
                if (q.bitIdx != 3'h0) begin
                    d.trial[q.bitIdx - 3'h1] = 1'b1;
                    d.bitIdx = q.bitIdx - 3'h1;
                end
            end
            if (finish) begin
                d.go = 1'b0;
                d.result = q.trial;
                d.flag = 1'b1;
            end
        end

        // start and abort
        if (startReq) begin
            d.go = 1'b1;
            d.activeSel = regWriteData[CLKSEL_LSB +: CLKSEL_W];
            d.tadCount = 4'h0;
            d.bitIdx = 3'h7;
            d.trial = 8'h00;
            d.restart = 1'b1;
        end else if (abortReq) begin
            d.go = 1'b0;
            // whatever bits were resolved so far become visible
            d.result = q.trial;
        end

        // Sleep entry wins over everything else
        if (sleepEnter) begin
            d.go = 1'b0;
            d.clkSel = CLKSEL_RESET;
            d.activeSel = CLKSEL_RESET;
            d.chanReq = CHAN_RESET;
            d.chanRoute = CHAN_RESET;
        end else if (!q.go) begin
            // the mux only follows a new channel between conversions
            d.chanRoute = d.chanReq;
        end

        // digital drive is blocked on analog pins, independent of ctrlOn
        d.pinOe = pinDriveReq & ~d.analog_pin_select;

        // read data stands only in the cycle after the strobe
        if (regRead) begin
            case (regAddr)
                OFS_CTRL: d.readData = {q.clkSel, q.chanReq, q.go, q.ctrlOn};
                OFS_PINSEL: d.readData = q.analog_pin_select;
                OFS_RESULT: d.readData = q.result;
                OFS_INTCTL: d.readData = {7'h00, q.flag};
                default: d.readData = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign regReadData = q.readData;
    assign pinDriveEn = q.pinOe;
    assign analogPinSelect = q.analog_pin_select;
    assign inputChannelSelect = q.chanRoute;
    assign trialCode = q.trial;
    assign convBusy = q.go;
    assign conversionDoneFlag = q.flag;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence startSeq;
        regWrite && (regAddr == OFS_CTRL) && regWriteData[BIT_GO] &&
            regWriteData[BIT_ON] && !q.go && !sleepEnter;
    endsequence

    sequence finishSeq;
        finish && !sleepEnter && !abortReq;
    endsequence

    start_sets_busy_a: assert property (@(posedge clock) disable iff (!nrst)
        startSeq |=> q.go && (q.tadCount == 4'h0) && q.restart)
        else $error("start did not raise busy");

    start_when_off_a: assert property (@(posedge clock) disable iff (!nrst)
        (wrCtrl && !regWriteData[BIT_ON] && !q.go) |=> !q.go)
        else $error("start accepted while converter off");

    done_sets_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        finishSeq |=> !q.go && q.flag)
        else $error("completion did not clear go and set flag");

    fresh_result_a: assert property (@(posedge clock) disable iff (!nrst)
        finishSeq |=> (q.result == $past(q.trial)))
        else $error("result not loaded at completion");

    thirteen_tad_a: assert property (@(posedge clock) disable iff (!nrst)
        $fell(q.go) && !$past(abortReq) && !$past(sleepEnter) |->
            ($past(q.tadCount) == LAST_TAD) && $past(tick))
        else $error("conversion did not last 13 bit periods");

    abort_stops_a: assert property (@(posedge clock) disable iff (!nrst)
        abortReq |=> !q.go ##1 !q.go || $past(startReq))
        else $error("abort did not stop conversion");

    sleep_stops_a: assert property (@(posedge clock) disable iff (!nrst)
        sleepEnter |=> !q.go && (q.clkSel == CLKSEL_RESET) &&
            (q.activeSel == CLKSEL_RESET))
        else $error("sleep left conversion or clock select");

    sleep_channel_a: assert property (@(posedge clock) disable iff (!nrst)
        sleepEnter |=> (q.chanReq == CHAN_RESET) && (q.chanRoute == CHAN_RESET))
        else $error("sleep kept channel selection");

    analog_no_drive_a: assert property (@(posedge clock) disable iff (!nrst)
        (q.pinOe & q.analog_pin_select) == 8'h00)
        else $error("digital drive on analog pin");

    pinsel_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        !$past(nrst) |-> (q.analog_pin_select == ANS_RESET))
        else $error("pin select not all ones after reset");

    channel_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        q.go && $past(q.go) && !$past(sleepEnter) |-> $stable(q.chanRoute))
        else $error("channel changed during conversion");

    clksel_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        q.go && $past(q.go) && !$past(sleepEnter) |-> $stable(q.activeSel))
        else $error("clock selector changed during conversion");

    flag_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
        q.flag && !(wrIntCtl && !regWriteData[BIT_DONE_FLAG]) |=> q.flag)
        else $error("done flag dropped without a clear");

endmodule // acc_conversion_control

`default_nettype wire

// file: testbench/acc_analog_model.sv
/*
  Behavioural analog side: one input level per channel and the comparator
  that answers the successive approximation trials.
  Assumes the bench sets the levels and holds them through a conversion.
*/
`timescale 1ns/1ps
`default_nettype none

module acc_analog_model
    import acc_pkg::*;
(
    // channel levels, in codes of the supply rail
    input wire logic [15:0][7:0] levels,
    // converter side
    input wire logic [CHAN_W-1:0] inputChannelSelect,
    input wire logic [7:0] trialCode,
    output logic compAbove
);
    // no external reference, so a level is a plain fraction of the supply
    assign compAbove = (levels[inputChannelSelect] >= trialCode);
endmodule // acc_analog_model

`default_nettype wire

// file: testbench/acc_conversion_control_tb.sv
/*
  Self-checking bench for the converter control block.
  Assumes the analog model answers trials at once and the core clock is 50 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module acc_conversion_control_tb
    import acc_pkg::*;
;
    localparam int ACQ_CYCLES = 8;
    localparam int OSC_PER = 3;
    logic clock;
    logic nrst;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0] regWriteData;
    logic [7:0] regReadData;
    logic regWrite;
    logic regRead;
    logic sleepEnter;
    logic intOscTick = 1'b0;
    logic [1:0] oscCnt = 2'h0;
    logic [7:0] pinDriveReq;
    logic [7:0] pinDriveEn;
    logic [7:0] analogPinSelect;
    logic compAbove;
    logic [CHAN_W-1:0] inputChannelSelect;
    logic [7:0] trialCode;
    logic convBusy;
    logic conversionDoneFlag;
    logic [15:0][7:0] levels;
    int failures = 0;
    int nChecks = 0;

    acc_conversion_control dut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .sleepEnter(sleepEnter), .intOscTick(intOscTick),
        .pinDriveReq(pinDriveReq), .pinDriveEn(pinDriveEn),
        .analogPinSelect(analogPinSelect), .compAbove(compAbove),
        .inputChannelSelect(inputChannelSelect), .trialCode(trialCode),
        .convBusy(convBusy), .conversionDoneFlag(conversionDoneFlag));

    acc_analog_model analog (.levels(levels), .inputChannelSelect(inputChannelSelect),
        .trialCode(trialCode), .compAbove(compAbove));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // slow oscillator enable, one pulse every OSC_PER cycles
    always @(posedge clock) begin
        oscCnt <= (oscCnt == 2'(OSC_PER - 1)) ? 2'h0 : oscCnt + 2'h1;
        intOscTick <= (oscCnt == 2'(OSC_PER - 1));
    end

    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkRange(input string what, input int lo, input int hi, input int got);
        nChecks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regReadData;
    endtask

    function automatic logic [7:0] ctrl(input logic [1:0] cs, input logic [3:0] ch,
                                        input logic go, input logic on);
        return {cs, ch, go, on};
    endfunction

    // bounded wait for the start/done bit to drop
    task automatic waitIdle();
        int n;
        n = 0;
        #1;
        while (convBusy === 1'b1) begin
            n++;
            if (n > 5000) begin
                failures++;
                test_done();
            end
            @(posedge clock);
            #1;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        pinDriveReq <= 8'hFF;
        rd(OFS_CTRL, d);
        chk8("ctrl reset", 8'h00, d);
        rd(OFS_PINSEL, d);
        chk8("pinsel reset", 8'hFF, d);
        rd(OFS_RESULT, d);
        chk8("result reset", RESULT_RESET, d);
        rd(OFS_INTCTL, d);
        chk8("intctl reset", 8'h00, d);
        rd(4'hF, d);
        chk8("unmapped read", 8'h00, d);
        chk8("drive blocked", 8'h00, pinDriveEn);
    endtask

    task automatic t_pins();
        pinDriveReq <= 8'h3C;
        wr(OFS_PINSEL, 8'h0F);
        repeat (2) @(posedge clock);
        #1;
        chk8("pin select port", 8'h0F, analogPinSelect);
        chk8("drive off", 8'h30, pinDriveEn);
        wr(OFS_CTRL, ctrl(2'h0, 4'h0, 1'b0, 1'b1));
        repeat (2) @(posedge clock);
        #1;
        chk8("drive on", 8'h30, pinDriveEn);
    endtask

    task automatic t_startOff();
        wr(OFS_CTRL, ctrl(2'h2, 4'h1, 1'b1, 1'b0));
        repeat (3) @(posedge clock);
        #1;
        chk8("busy while off", 8'h00, {7'h00, convBusy});
    endtask

    task automatic runConv(input logic [1:0] cs, input logic [3:0] ch);
        int div;
        int per;
        time t0;
        logic [7:0] d;
        div = (cs == 2'h0) ? 16 : (cs == 2'h1) ? 8 : 4;
        per = (cs == CLKSEL_INTERNAL_OSCILLATOR) ? OSC_PER : 1;
        wr(OFS_INTCTL, 8'h00);
        wr(OFS_CTRL, ctrl(cs, ch, 1'b0, 1'b1));
        repeat (ACQ_CYCLES) @(posedge clock);
        wr(OFS_CTRL, ctrl(cs, ch, 1'b1, 1'b1));
        t0 = $time;
        rd(OFS_CTRL, d);
        chk8("go reads one", 8'h02, d & 8'h02);
        waitIdle();
        chk8("flag at finish", 8'h01, {7'h00, conversionDoneFlag});
        chkRange("conv cycles", 13 * div * per - per, 13 * div * per + 2 * per + 6,
                 int'(($time - t0) / 20));
        rd(OFS_RESULT, d);
        chk8("result", levels[ch], d);
    endtask

    task automatic t_divisors();
        logic [7:0] d;
        for (int cs = 0; cs < 4; cs++) begin
            // the slow-oscillator code stands for a core clock below the divider range
            runConv(2'(cs), 4'(cs + 1));
        end
        wr(OFS_INTCTL, 8'h01);
        rd(OFS_INTCTL, d);
        chk8("flag kept", 8'h01, d);
        wr(OFS_INTCTL, 8'h00);
        rd(OFS_INTCTL, d);
        chk8("flag cleared", 8'h00, d);
    endtask

    task automatic t_midChange();
        time t0;
        logic [7:0] d;
        wr(OFS_CTRL, ctrl(2'h2, 4'h3, 1'b0, 1'b1));
        repeat (ACQ_CYCLES) @(posedge clock);
        wr(OFS_CTRL, ctrl(2'h2, 4'h3, 1'b1, 1'b1));
        t0 = $time;
        repeat (10) @(posedge clock);
        // channel and clock select rewritten while converting
        wr(OFS_CTRL, ctrl(2'h0, 4'h9, 1'b1, 1'b1));
        #1;
        chk8("old channel", 8'h03, {4'h0, inputChannelSelect});
        waitIdle();
        chkRange("old divisor", 51, 58, int'(($time - t0) / 20));
        rd(OFS_RESULT, d);
        chk8("result old ch", levels[3], d);
        chk8("new channel", 8'h09, {4'h0, inputChannelSelect});
    endtask

    task automatic t_abort();
        wr(OFS_INTCTL, 8'h00);
        wr(OFS_CTRL, ctrl(2'h2, 4'h1, 1'b1, 1'b1));
        repeat (20) @(posedge clock);
        wr(OFS_CTRL, ctrl(2'h2, 4'h1, 1'b0, 1'b1));
        @(posedge clock);
        #1;
        chk8("busy after abort", 8'h00, {7'h00, convBusy});
        chk8("no flag", 8'h00, {7'h00, conversionDoneFlag});
    endtask

    task automatic t_sleep();
        logic [7:0] d;
        wr(OFS_CTRL, ctrl(2'h1, 4'h5, 1'b1, 1'b1));
        repeat (10) @(posedge clock);
        sleepEnter <= 1'b1;
        @(posedge clock);
        sleepEnter <= 1'b0;
        @(posedge clock);
        #1;
        chk8("busy in sleep", 8'h00, {7'h00, convBusy});
        chk8("channel lost", 8'h00, {4'h0, inputChannelSelect});
        rd(OFS_CTRL, d);
        chk8("ctrl after sleep", 8'h00, d & 8'hFE);
    endtask

    task automatic t_resultRw();
        logic [7:0] d;
        wr(OFS_RESULT, 8'hA5);
        rd(OFS_RESULT, d);
        chk8("result rw", 8'hA5, d);
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            levels[i] = 8'(i * 29 + 7);
        end
        levels[1] = 8'hFF;
        levels[2] = 8'h00;
        nrst = 1'b0;
        regAddr = '0;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        sleepEnter = 1'b0;
        pinDriveReq = 8'h00;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_pins();
        t_startOff();
        t_divisors();
        t_midChange();
        t_abort();
        t_sleep();
        t_resultRw();
        test_done();
    end
endmodule // acc_conversion_control_tb

`default_nettype wire
